// ---- verilog/mtc_pkg.sv ----
// Shared constants and types for the MAC transmit control block.
// Assumes a single core clock domain and a 32-bit AXI4-Lite register bus.
package mtc_pkg;
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  TXCTL_OFF   = 8'h70;
	localparam logic [7:0]  TXSTAT_OFF  = 8'h7C;
	localparam int          B_RUN       = 0;
	localparam int          B_CRC       = 1;
	localparam int          B_PAD       = 2;
	localparam int          B_FCE       = 3;
	localparam int          B_FLUSH     = 4;
	localparam int          B_IP        = 5;
	localparam int          B_TCP       = 6;
	localparam int          B_ICMP      = 8;
	localparam logic [15:0] CTL_WMASK   = 16'h017F;
	localparam logic [15:0] CTL_RST     = 16'h0000;
	localparam logic [6:0]  PAD_MIN     = 7'h3C;
	localparam logic [6:0]  LEN_SAT     = 7'h7F;
	localparam logic [1:0]  CRC_LAST    = 2'h3;
	localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MTC_IDLE, MTC_DATA, MTC_PAD, MTC_CRC} mtc_state_t;
endpackage : mtc_pkg

// ---- verilog/mtc_crc_if.sv ----
// Connection between the transmit sequencer and its CRC engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface mtc_crc_if;
	logic        clear;
	logic        en;
	logic [7:0]  data;
	logic [31:0] crc;

	modport engine (input clear, input en, input data, output crc);
	modport user   (output clear, output en, output data, input crc);
endinterface : mtc_crc_if

// ---- verilog/mtc_crc32.sv ----
// Byte-wise Ethernet CRC-32 engine, LSB first, complemented result.
// Assumes clear and en come from logic on the same clock.
`timescale 1ns/10ps
module mtc_crc32
	import mtc_pkg::*;
(
	input  logic        clock,
	input  logic        srst,
	mtc_crc_if.engine   crc_if
);
	logic [31:0] state_r;
	logic [31:0] state_nxt;

	always_comb
	begin
		state_nxt = state_r ^ {24'h000000, crc_if.data};
		for (int i = 0; i < 8; i++)
			state_nxt = state_nxt[0] ? ((state_nxt >> 1) ^ CRC_POLY) : (state_nxt >> 1);
	end

	always_ff @(posedge clock)
	begin
		if (srst || crc_if.clear)
			state_r <= CRC_INIT;
		else if (crc_if.en)
			state_r <= state_nxt;
	end

	assign crc_if.crc = ~state_r;

	// The appended bytes are read over four cycles, so the value must hold still
	property p_crc_hold;
		@(posedge clock) disable iff (srst)
		!crc_if.en && !crc_if.clear |=> $stable(crc_if.crc);
	endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("crc changed while idle"); // [R11]
endmodule : mtc_crc32

// ---- verilog/mtc_flow_ctrl.sv ----
// Transmit flow control: pause request in full duplex, backpressure in half.
// Assumes over_thresh and full_dup are already in the core clock domain.
`timescale 1ns/10ps
module mtc_flow_ctrl
	import mtc_pkg::*;
(
	input  logic clock,
	input  logic srst,
	input  logic fc_en,
	input  logic full_dup,
	input  logic over_thresh,
	output logic pause_req,
	output logic backpres
);
	logic over_d_r;

	always_ff @(posedge clock)
	begin
		if (srst)
			over_d_r <= 1'b0;
		else
			over_d_r <= over_thresh;
	end

	// One request per crossing, so a long fill does not flood the link with pauses
	always_ff @(posedge clock)
	begin
		if (srst)
			pause_req <= 1'b0;
		else
			pause_req <= fc_en && full_dup && over_thresh && !over_d_r; // [R6] [R8]
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			backpres <= 1'b0;
		else
			backpres <= fc_en && !full_dup && over_thresh; // [R7] [R8]
	end

	property p_pause;
		@(posedge clock) disable iff (srst)
		fc_en && full_dup && over_thresh && !over_d_r |=> pause_req && !backpres;
	endproperty
	a_pause: assert property (p_pause) else $error("pause not requested"); // [R6]

	property p_bp;
		@(posedge clock) disable iff (srst)
		fc_en && !full_dup && over_thresh |=> backpres && !pause_req;
	endproperty
	a_bp: assert property (p_bp) else $error("backpressure not applied"); // [R7]

	property p_nofc;
		@(posedge clock) disable iff (srst)
		!fc_en |=> !pause_req && !backpres;
	endproperty
	a_nofc: assert property (p_nofc) else $error("flow control while disabled"); // [R8]

	c_pause: cover property (@(posedge clock) disable iff (srst) pause_req);
endmodule : mtc_flow_ctrl

// ---- verilog/mtc_tx_ctrl.sv ----
// MAC transmit control: control register, frame sequencer, pad and CRC append.
// Assumes an AXI4-Lite master, a byte queue on the same clock, a PHY taking a
// byte per clock while tx_en is high, and duplex arriving from a pin.
//
// What this block does, and what software must do (R5, R10)
// (R1) ICMP checksum insert only for unfragmented frames
// (R2) TCP checksum insert on TCP frames when enabled
// (R3) IP header checksum insert when enabled
// (R4) Flush clears queue and frame pointer
// (R5) Software stops transmit before flush, then unflushes
// (R6) Full duplex: pause request at buffer threshold
// (R7) Half duplex: backpressure instead of pause
// (R8) Flow control off: no pause, no backpressure
// (R9) Pad frames shorter than minimum when enabled
// (R10) Software enables CRC whenever padding is on
// (R11) Append 32-bit CRC when enabled
// (R12) Run bit starts the transmit engine
// (R13) Clearing run stops after current frame
// (R14) Reset reads zero, reserved bits read zero
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mtc_tx_ctrl
	import mtc_pkg::*;
(
	input  logic              clock,
	input  logic              srst,
	input  logic [ADDR_W-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	input  logic [ADDR_W-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	input  logic [7:0]        q_data,
	input  logic              q_valid,
	input  logic              q_last,
	input  logic              q_is_ip,
	input  logic              q_is_tcp,
	input  logic              q_is_icmp,
	input  logic              q_is_frag,
	output logic              q_ready,
	output logic              q_clear,
	input  logic              full_duplex,
	input  logic              rx_over_thresh,
	output logic [7:0]        tx_data,
	output logic              tx_en,
	output logic              tx_eof,
	output logic              csum_ip_ins,
	output logic              csum_tcp_ins,
	output logic              csum_icmp_ins,
	output logic              pause_req,
	output logic              backpressure
);
	logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r;
	logic              aw_have_r, w_have_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic [15:0]       ctl_r;
	logic [15:0]       status;
	logic              fdx_s1_r, fdx_s2_r;
	logic              running_r;
	logic [7:0]        tx_frame_ptr_r;
	mtc_state_t        st_r, st_nxt;
	logic              q_ready_r, q_clear_r, tx_en_r, tx_eof_r;
	logic [7:0]        tx_data_r;
	logic              pad_f_r, crc_f_r;
	logic              csum_ip_r, csum_tcp_r, csum_icmp_r;
	logic [6:0]        len_r, len_inc;
	logic [1:0]        crc_idx_r;
	logic              aw_take, w_take, ar_take, wr_go, accept, frame_start, frame_end;
	logic [ADDR_W-1:0] aw_word, ar_word;
	logic [7:0]        crc_byte;

	mtc_crc_if crc_bus ();

	mtc_crc32 u_crc (
		.clock  (clock),
		.srst   (srst),
		.crc_if (crc_bus)
	);

	mtc_flow_ctrl u_flow (
		.clock       (clock),
		.srst        (srst),
		.fc_en       (ctl_r[B_FCE]),
		.full_dup    (fdx_s2_r),
		.over_thresh (rx_over_thresh),
		.pause_req   (pause_req),
		.backpres    (backpressure)
	);

	assign aw_take = awvalid && awready_r;
	assign w_take  = wvalid && wready_r;
	assign ar_take = arvalid && arready_r;
	assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
	assign aw_word = {aw_addr_r[ADDR_W-1:2], 2'h0};
	assign ar_word = {araddr[ADDR_W-1:2], 2'h0};

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end
		else if (aw_take)
		begin
			aw_have_r <= 1'b1;
			aw_addr_r <= awaddr;
		end
		else if (wr_go)
			aw_have_r <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end
		else if (w_take)
		begin
			w_have_r <= 1'b1;
			w_data_r <= wdata;
			w_strb_r <= wstrb;
		end
		else if (wr_go)
			w_have_r <= 1'b0;
	end

	// Each channel accepts one item, then waits until the write is done
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
		end
		else
		begin
			awready_r <= !(aw_take || (aw_have_r && !wr_go));
			wready_r  <= !(w_take || (w_have_r && !wr_go));
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= (aw_word == TXCTL_OFF || aw_word == TXSTAT_OFF) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid_r <= 1'b0;
	end

	// Reserved bits never store, so they read zero whatever was written
	always_ff @(posedge clock)
	begin
		if (srst)
			ctl_r <= CTL_RST; // [R14]
		else if (wr_go && aw_word == TXCTL_OFF)
		begin
			ctl_r <= {w_strb_r[1] ? w_data_r[15:8] : ctl_r[15:8],
				  w_strb_r[0] ? w_data_r[7:0] : ctl_r[7:0]} & CTL_WMASK; // [R14]
		end
	end

	assign status = {tx_frame_ptr_r, 4'h0, backpressure, fdx_s2_r, (st_r != MTC_IDLE), running_r};

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= RESP_OKAY;
		end
		else
		begin
			arready_r <= !(ar_take || (rvalid_r && !rready));
			if (ar_take)
			begin
				rvalid_r <= 1'b1;
				rresp_r  <= RESP_OKAY;
				if (ar_word == TXCTL_OFF)
					rdata_r <= {16'h0000, ctl_r};
				else if (ar_word == TXSTAT_OFF)
					rdata_r <= {16'h0000, status};
				else
				begin
					rdata_r <= '0;
					rresp_r <= RESP_SLVERR;
				end
			end
			else if (rready)
				rvalid_r <= 1'b0;
		end
	end

	// Duplex comes from the PHY pin, outside this clock
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			fdx_s1_r <= 1'b0;
			fdx_s2_r <= 1'b0;
		end
		else
		begin
			fdx_s1_r <= full_duplex;
			fdx_s2_r <= fdx_s1_r;
		end
	end

	assign accept      = q_ready_r && q_valid;
	assign len_inc     = (len_r == LEN_SAT) ? LEN_SAT : len_r + 7'h01;
	assign frame_start = (st_r == MTC_IDLE) && (st_nxt == MTC_DATA);
	assign frame_end   = (st_r != MTC_IDLE) && (st_nxt == MTC_IDLE);
	assign crc_byte    = crc_bus.crc[{crc_idx_r, 3'h0} +: 8];

	// Run is only looked at between frames, so a cleared run lets the frame end
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			MTC_IDLE:
				if (ctl_r[B_RUN] && !ctl_r[B_FLUSH] && q_valid) // [R12] [R4]
					st_nxt = MTC_DATA;
			MTC_DATA:
				if (accept && q_last) // [R13]
				begin
					if (pad_f_r && len_inc < PAD_MIN) // [R9]
						st_nxt = MTC_PAD;
					else if (crc_f_r) // [R11]
						st_nxt = MTC_CRC;
					else
						st_nxt = MTC_IDLE;
				end
			MTC_PAD:
				if (len_inc == PAD_MIN)
					st_nxt = crc_f_r ? MTC_CRC : MTC_IDLE; // [R11]
			MTC_CRC:
				if (crc_idx_r == CRC_LAST)
					st_nxt = MTC_IDLE;
			default:
				st_nxt = MTC_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			st_r <= MTC_IDLE;
		else
			st_r <= st_nxt;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			running_r <= 1'b0;
		else if (ctl_r[B_RUN])
			running_r <= 1'b1; // [R12]
		else if (st_nxt == MTC_IDLE)
			running_r <= 1'b0; // [R13]
	end

	// Options are frozen per frame so a register write cannot split a frame
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			pad_f_r     <= 1'b0;
			crc_f_r     <= 1'b0;
			csum_ip_r   <= 1'b0;
			csum_tcp_r  <= 1'b0;
			csum_icmp_r <= 1'b0;
		end
		else if (frame_start)
		begin
			pad_f_r     <= ctl_r[B_PAD]; // [R9]
			crc_f_r     <= ctl_r[B_CRC]; // [R11]
			csum_ip_r   <= ctl_r[B_IP] && q_is_ip; // [R3]
			csum_tcp_r  <= ctl_r[B_TCP] && q_is_tcp; // [R2]
			csum_icmp_r <= ctl_r[B_ICMP] && q_is_icmp && !q_is_frag; // [R1]
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst || frame_start)
			len_r <= '0;
		else if (accept || st_r == MTC_PAD)
			len_r <= len_inc;
	end

	always_ff @(posedge clock)
	begin
		if (srst || st_r != MTC_CRC)
			crc_idx_r <= '0;
		else
			crc_idx_r <= crc_idx_r + 2'h1;
	end

	assign crc_bus.clear = frame_start;
	assign crc_bus.en    = accept || st_r == MTC_PAD;
	assign crc_bus.data  = accept ? q_data : 8'h00;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			q_ready_r <= 1'b0;
			tx_en_r   <= 1'b0;
			tx_data_r <= 8'h00;
			tx_eof_r  <= 1'b0;
		end
		else
		begin
			q_ready_r <= (st_nxt == MTC_DATA);
			tx_en_r   <= accept || st_r == MTC_PAD || st_r == MTC_CRC;
			tx_data_r <= accept ? q_data : (st_r == MTC_CRC) ? crc_byte : 8'h00; // [R9] [R11]
			tx_eof_r  <= frame_end;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			tx_frame_ptr_r <= 8'h00;
			q_clear_r      <= 1'b0;
		end
		else
		begin
			q_clear_r <= ctl_r[B_FLUSH]; // [R4]
			if (ctl_r[B_FLUSH])
				tx_frame_ptr_r <= 8'h00; // [R4]
			else if (frame_end)
				tx_frame_ptr_r <= tx_frame_ptr_r + 8'h01;
		end
	end

	assign awready       = awready_r;
	assign wready        = wready_r;
	assign bvalid        = bvalid_r;
	assign bresp         = bresp_r;
	assign arready       = arready_r;
	assign rvalid        = rvalid_r;
	assign rdata         = rdata_r;
	assign rresp         = rresp_r;
	assign q_ready       = q_ready_r;
	assign q_clear       = q_clear_r;
	assign tx_en         = tx_en_r;
	assign tx_data       = tx_data_r;
	assign tx_eof        = tx_eof_r;
	assign csum_ip_ins   = csum_ip_r;
	assign csum_tcp_ins  = csum_tcp_r;
	assign csum_icmp_ins = csum_icmp_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	property p_icmp;
		frame_start && ctl_r[B_ICMP] && q_is_icmp && !q_is_frag |=> csum_icmp_ins;
	endproperty
	a_icmp: assert property (p_icmp) else $error("icmp checksum not enabled"); // [R1]

	property p_icmp_frag;
		frame_start && q_is_frag |=> !csum_icmp_ins;
	endproperty
	a_icmp_frag: assert property (p_icmp_frag) else $error("icmp on fragment"); // [R1]

	property p_tcp;
		frame_start |=> csum_tcp_ins == ($past(ctl_r[B_TCP]) && $past(q_is_tcp));
	endproperty
	a_tcp: assert property (p_tcp) else $error("tcp checksum flag wrong"); // [R2]

	property p_ip;
		frame_start |=> csum_ip_ins == ($past(ctl_r[B_IP]) && $past(q_is_ip));
	endproperty
	a_ip: assert property (p_ip) else $error("ip checksum flag wrong"); // [R3]

	property p_flush;
		ctl_r[B_FLUSH] && st_r == MTC_IDLE |=> q_clear && tx_frame_ptr_r == 8'h00 && st_r == MTC_IDLE;
	endproperty
	a_flush: assert property (p_flush) else $error("flush did not clear"); // [R4]

	property p_pad_go;
		st_r == MTC_DATA && accept && q_last && pad_f_r && len_inc < PAD_MIN |=> st_r == MTC_PAD;
	endproperty
	a_pad_go: assert property (p_pad_go) else $error("short frame not padded"); // [R9]

	property p_pad;
		st_r == MTC_PAD |=> tx_en && tx_data == 8'h00;
	endproperty
	a_pad: assert property (p_pad) else $error("pad byte wrong"); // [R9]

	sequence s_crc_enter;
		(st_r != MTC_CRC) ##1 (st_r == MTC_CRC);
	endsequence
	property p_crc;
		s_crc_enter |-> (st_r == MTC_CRC)[*4] ##1 (st_r == MTC_IDLE && tx_eof);
	endproperty
	a_crc: assert property (p_crc) else $error("crc not four bytes"); // [R11]

	property p_run;
		st_r == MTC_IDLE && ctl_r[B_RUN] && !ctl_r[B_FLUSH] && q_valid |=> st_r == MTC_DATA && q_ready;
	endproperty
	a_run: assert property (p_run) else $error("run did not start frame"); // [R12]

	property p_stop;
		st_r == MTC_DATA && !(accept && q_last) |=> st_r == MTC_DATA;
	endproperty
	a_stop: assert property (p_stop) else $error("frame cut short"); // [R13]

	property p_idle_stop;
		st_r == MTC_IDLE && !ctl_r[B_RUN] |=> st_r == MTC_IDLE && !q_ready;
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("started while stopped"); // [R13]

	property p_rsv;
		ar_take && ar_word == TXCTL_OFF |=> rdata[15:9] == 7'h00 && !rdata[7] && rdata[31:16] == 16'h0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits nonzero"); // [R14]

	c_pad_crc: cover property (st_r == MTC_PAD ##1 st_r == MTC_CRC);
	c_flush: cover property (ctl_r[B_FLUSH] ##1 q_clear);
	c_stop_mid: cover property (st_r == MTC_DATA && !ctl_r[B_RUN] ##1 tx_eof);
endmodule : mtc_tx_ctrl

// ---- tb/mtc_phy_model.sv ----
// PHY-side model of the transmit path: collects bytes and counts frames.
// Assumes tx_en marks each byte and tx_eof the final byte of a frame.
`timescale 1ns/10ps
module mtc_phy_model (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_en,
	input  wire logic       tx_eof,
	input  wire logic       dup_sel,
	output logic            full_duplex
);
	logic [7:0] rx_q[$];
	int         frames;

	// Duplex is what autonegotiation settled on; the bench picks it
	assign full_duplex = dup_sel;

	always @(posedge clock)
	begin
		if (srst)
		begin
			rx_q.delete();
			frames = 0;
		end
		else
		begin
			if (tx_en)
				rx_q.push_back(tx_data);
			if (tx_en && tx_eof)
				frames = frames + 1;
		end
	end
endmodule : mtc_phy_model

// ---- tb/mtc_tx_ctrl_tb.sv ----
// Self-checking bench for the MAC transmit control block.
// Assumes the PHY model on the transmit side; the bench is the host and queue.
`timescale 1ns/10ps
module mtc_tx_ctrl_tb;
	import mtc_pkg::*;
	logic       clock, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic       arvalid, arready, rvalid, rready, q_valid, q_last, q_ready, q_clear;
	logic       q_is_ip, q_is_tcp, q_is_icmp, q_is_frag, full_duplex, rx_over_thresh;
	logic       tx_en, tx_eof, csum_ip_ins, csum_tcp_ins, csum_icmp_ins;
	logic       pause_req, backpressure, dup_sel;
	logic [7:0] awaddr, araddr, q_data, tx_data;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int         err_total, cmp_count;
	logic [31:0] d;
	logic [1:0] r;
	logic [15:0] ctl;
	int         len, np;
	int         corner[4] = '{1, 59, 60, 61};

	mtc_tx_ctrl mtc_tx_ctrl_inst (.clock, .srst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .q_data, .q_valid, .q_last, .q_is_ip, .q_is_tcp,
		.q_is_icmp, .q_is_frag, .q_ready, .q_clear, .full_duplex, .rx_over_thresh, .tx_data,
		.tx_en, .tx_eof, .csum_ip_ins, .csum_tcp_ins, .csum_icmp_ins, .pause_req,
		.backpressure);
	mtc_phy_model mtc_phy_model_inst (.clock, .srst, .tx_data, .tx_en, .tx_eof, .dup_sel,
		.full_duplex);

	always #25 clock = ~clock;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic hang();
		err_total++;
		$display("MISMATCH at %0t: wait ran out", $time);
		complete_run();
	endtask : hang

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH at %0t: register got %h want %h", $time, g, e);
		end
	endtask : chk_reg

	task automatic chk_wire(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH at %0t: port got %h want %h", $time, g, e);
		end
	endtask : chk_wire

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		rs = bresp;
		// Ready stays high: lowering it here would clash with the next write raising it
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Reflected Ethernet CRC worked bit by bit, independent of the engine
	function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
		logic [31:0] c = 32'hFFFFFFFF;
		foreach (b[i])
		begin
			c ^= {24'h000000, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
		end
		return ~c;
	endfunction : crc_of

	task automatic send_frame(input int n_b, input logic [15:0] c);
		logic [7:0] b[$];
		logic [7:0] e[$];
		logic [31:0] k;
		logic ip, tcp, icmp, frag;
		int i, n, f0;
		{ip, tcp, icmp, frag} = 4'($urandom);
		for (i = 0; i < n_b; i++)
			b.push_back(8'($urandom));
		e = b;
		if (c[B_PAD])
			while (e.size() < 60) e.push_back(8'h00);
		k = crc_of(e);
		if (c[B_CRC])
			for (i = 0; i < 4; i++) e.push_back(k[8*i +: 8]);
		mtc_phy_model_inst.rx_q.delete();
		f0 = mtc_phy_model_inst.frames;
		{q_is_ip, q_is_tcp, q_is_icmp, q_is_frag} <= {ip, tcp, icmp, frag};
		q_valid <= 1'b1;
		q_data <= b[0];
		q_last <= (n_b == 1);
		i = 0;
		n = 0;
		while (i < n_b && n < 500)
		begin
			@(posedge clock);
			n++;
			if (q_valid && q_ready)
			begin
				i++;
				q_data <= (i < n_b) ? b[i] : 8'h00;
				q_last <= (i == n_b - 1);
				q_valid <= (i < n_b);
			end
		end
		// Frame count moves on a rising edge; look at it half a cycle later
		while (mtc_phy_model_inst.frames == f0 && n < 700)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= 700)
			hang();
		chk_wire(32'(mtc_phy_model_inst.rx_q.size()), 32'(e.size()));
		foreach (e[j])
			chk_wire({24'h0, mtc_phy_model_inst.rx_q[j]}, {24'h0, e[j]});
		chk_wire({31'h0, csum_ip_ins}, {31'h0, c[B_IP] & ip});
		chk_wire({31'h0, csum_tcp_ins}, {31'h0, c[B_TCP] & tcp});
		chk_wire({31'h0, csum_icmp_ins}, {31'h0, c[B_ICMP] & icmp & ~frag});
		@(posedge clock);
	endtask : send_frame

	task automatic flow(input logic fce, input logic fd, input int e_p, input logic e_bp);
		dup_sel <= fd;
		axi_wr(TXCTL_OFF, {12'h000, fce, 3'h0}, r);
		repeat (5) @(posedge clock);
		rx_over_thresh <= 1'b1;
		np = 0;
		repeat (6) @(negedge clock) np += (pause_req === 1'b1);
		chk_wire(32'(np), 32'(e_p));
		chk_wire({31'h0, backpressure}, {31'h0, e_bp});
		@(posedge clock);
		rx_over_thresh <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : flow

	initial
	begin
		{clock, awvalid, wvalid, bready, arvalid, rready, q_valid, q_last} = '0;
		{q_is_ip, q_is_tcp, q_is_icmp, q_is_frag, rx_over_thresh, dup_sel} = '0;
		{awaddr, araddr, q_data, wdata} = '0;
		wstrb = 4'h3;
		srst = 1'b1;
		err_total = 0;
		cmp_count = 0;
		void'($urandom(32'hA47BA248));
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		axi_rd(TXCTL_OFF, d, r);
		chk_reg(d, 32'h0);
		axi_wr(TXCTL_OFF, 16'hFFEE, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		axi_rd(TXCTL_OFF, d, r);
		chk_reg(d, 32'h016E);
		axi_wr(8'h40, 16'h1234, r);
		chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_rd(8'h40, d, r);
		chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test registers done");
		for (int k = 0; k < 8; k++)
		begin
			ctl = 16'($urandom) & 16'h0166;
			// Short corners always pad, so the pad path is hit whatever the seed
			if (k < 2)
				ctl[B_PAD] = 1'b1;
			// Padding goes only with CRC on
			if (ctl[B_PAD])
				ctl[B_CRC] = 1'b1;
			ctl[B_RUN] = 1'b1;
			len = (k < 4) ? corner[k] : 1 + ($urandom % 70);
			axi_wr(TXCTL_OFF, ctl, r);
			send_frame(len, ctl);
		end
		$display("test frames done");
		// CRC off here, so the cut frame ends on its own last data byte
		axi_wr(TXCTL_OFF, 16'h0001, r);
		fork
			send_frame(30, 16'h0001);
			begin
				repeat (8) @(posedge clock);
				axi_wr(TXCTL_OFF, 16'h0000, r);
			end
		join
		q_valid <= 1'b1;
		np = 0;
		repeat (10) @(negedge clock) np += (q_ready === 1'b1);
		chk_wire(32'(np), 32'h0);
		q_valid <= 1'b0;
		$display("test stop done");
		axi_wr(TXCTL_OFF, 16'h0000, r);
		axi_wr(TXCTL_OFF, 16'h0010, r);
		repeat (2) @(negedge clock);
		chk_wire({31'h0, q_clear}, 32'h1);
		axi_rd(TXSTAT_OFF, d, r);
		chk_reg({24'h0, d[15:8]}, 32'h0);
		axi_wr(TXCTL_OFF, 16'h0000, r);
		repeat (3) @(negedge clock);
		chk_wire({31'h0, q_clear}, 32'h0);
		$display("test flush done");
		flow(1'b1, 1'b1, 1, 1'b0);
		flow(1'b1, 1'b0, 0, 1'b1);
		flow(1'b0, 1'b1, 0, 1'b0);
		flow(1'b0, 1'b0, 0, 1'b0);
		$display("test flow done");
		complete_run();
	end
endmodule : mtc_tx_ctrl_tb
